// ---- irt_timer.sv ----
// irt_timer: ir timer input circuit, short timer transmit and register file
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - input source from port3 mode bits and input-select bit.
// - edge pulse on rising, falling or any edge by edge-select field.
// - glitches shorter than selected filter width removed before edges.
// - both timers share the single selected, filtered input.
// - disabled short timer output is inverse of initial-level bit.
// - on enable, output takes initial level; load low or high hold.
// - single-pass counts to zero, stops, toggles, sets time-out, interrupts.
// - repeating mode first terminal count toggles only, reloads by level.
// - second terminal count toggles, sets time-out, interrupts, repeats.
// - hold writes always accepted, used only at next load.
// - initial count zero wraps to FFh and keeps counting down.
// - wrap from zero to FFh is no time-out.
// - short timer output drives port3 pin4 when output enable set.
module irt_timer #(
  parameter int GLITCH_CNT_W = 4
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // interrupt
  output logic             irq,
  // input sources
  input  wire logic        port3_pin1_input,
  input  wire logic        comparator_output,
  input  wire logic        ir_amp_output,
  input  wire logic        port2_pin0_input,
  input  wire logic [1:0]  port3_mode,
  // filtered input and edge pulse for demodulation
  output logic             input_level,
  output logic             input_edge_pulse,
  // timer output pin
  output logic             short_timer_output,
  output logic             port3_pin4_output,
  output logic             port3_pin4_oe_n
);

  // register storage
  logic [7:0] short_ctrl_reg;
  logic [7:0] short_ctrl_next;
  logic [7:0] common_ctrl_reg;
  logic [7:0] long_ctrl_reg;
  logic [7:0] extra_ctrl_reg;
  logic [7:0] short_low_reg;
  logic [7:0] short_high_reg;
  logic [7:0] long_low_reg;
  logic [7:0] long_high_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // input circuit state
  logic       sync1_reg;
  logic       sync2_reg;
  logic       sync3_reg;
  logic       stable_reg;
  logic       filt_reg;
  logic       filt_next;
  logic       filt_d_reg;
  logic [GLITCH_CNT_W-1:0] glitch_cnt_reg;
  logic [GLITCH_CNT_W-1:0] glitch_cnt_next;

  // short timer state
  irt_pkg::irt_state_t state_reg;
  irt_pkg::irt_state_t state_next;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic       out_reg;
  logic       out_next;
  logic       second_reg;
  logic       second_next;
  logic       timeout_set;
  logic       stop_hw;

  // decoded strobes
  wire wr_short_ctrl  = reg_write && reg_addr == irt_pkg::ADDR_SHORT_CTRL;
  wire wr_common_ctrl = reg_write && reg_addr == irt_pkg::ADDR_COMMON_CTRL;
  wire wr_long_ctrl   = reg_write && reg_addr == irt_pkg::ADDR_LONG_CTRL;
  wire wr_extra_ctrl  = reg_write && reg_addr == irt_pkg::ADDR_EXTRA_CTRL;
  wire wr_short_low   = reg_write && reg_addr == irt_pkg::ADDR_SHORT_LOW;
  wire wr_short_high  = reg_write && reg_addr == irt_pkg::ADDR_SHORT_HIGH;
  wire wr_long_low    = reg_write && reg_addr == irt_pkg::ADDR_LONG_LOW;
  wire wr_long_high   = reg_write && reg_addr == irt_pkg::ADDR_LONG_HIGH;
  wire rd_short_ctrl  = reg_read && reg_addr == irt_pkg::ADDR_SHORT_CTRL;

  // named control fields
  wire       enable_bit  = short_ctrl_reg[irt_pkg::SC_ENABLE];
  wire       single_pass = short_ctrl_reg[irt_pkg::SC_SINGLE];
  wire       init_level  = common_ctrl_reg[irt_pkg::CC_SHORT_INIT];
  wire       input_sel   = common_ctrl_reg[irt_pkg::CC_INPUT_SEL];
  wire [1:0] edge_sel    = common_ctrl_reg[irt_pkg::CC_EDGE_HI:
                                           irt_pkg::CC_EDGE_LO];
  wire [1:0] glitch_sel  = common_ctrl_reg[irt_pkg::CC_GLITCH_HI:
                                           irt_pkg::CC_GLITCH_LO];

  // hold register picked by an output level
  function automatic logic [7:0] hold_for(input logic level,
                                          input logic [7:0] low,
                                          input logic [7:0] high);
    hold_for = level ? high : low;
  endfunction : hold_for

  // filter width for a width code
  function automatic logic [3:0] glitch_width(input logic [1:0] code);
    case (code)
      2'h0:    glitch_width = irt_pkg::GLITCH_W0;
      2'h1:    glitch_width = irt_pkg::GLITCH_W1;
      2'h2:    glitch_width = irt_pkg::GLITCH_W2;
      default: glitch_width = irt_pkg::GLITCH_W3;
    endcase
  endfunction : glitch_width

  // ---------------------------------------------------------------
  // input circuit
  // ---------------------------------------------------------------

  // source mux ahead of the synchroniser; all sources are asynchronous
  wire port3_src = port3_mode[1] ? ir_amp_output :
                   (port3_mode[0] ? comparator_output
                                  : port3_pin1_input);
  wire raw_input = input_sel ? port2_pin0_input : port3_src;

  // three-stage synchroniser; sync1 feeds sync2 only
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= raw_input;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge mclk) begin
    if (reset) begin
      stable_reg <= 1'b0;
    end else if (sync2_reg == sync3_reg) begin
      stable_reg <= sync3_reg;
    end
  end

  // glitch filter: a new level must persist the full width to pass
  wire glitch_diff = stable_reg != filt_reg;
  wire glitch_done = GLITCH_CNT_W'(glitch_width(glitch_sel))
                     <= glitch_cnt_reg;

  always_comb begin
    filt_next       = filt_reg;
    glitch_cnt_next = '0;
    if (glitch_diff) begin
      if (glitch_done) begin
        filt_next = stable_reg;
      end else begin
        glitch_cnt_next = glitch_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      filt_reg       <= 1'b0;
      filt_d_reg     <= 1'b0;
      glitch_cnt_reg <= '0;
    end else begin
      filt_reg       <= filt_next;
      filt_d_reg     <= filt_reg;
      glitch_cnt_reg <= glitch_cnt_next;
    end
  end

  // edge detection on the filtered level, shared by both timers
  wire rise_seen = filt_reg && !filt_d_reg;
  wire fall_seen = !filt_reg && filt_d_reg;
  assign input_level      = filt_reg;
  assign input_edge_pulse =
      (edge_sel == irt_pkg::EDGE_RISING  && rise_seen) ||
      (edge_sel == irt_pkg::EDGE_FALLING && fall_seen) ||
      (edge_sel == irt_pkg::EDGE_ANY && (rise_seen || fall_seen));

  // ---------------------------------------------------------------
  // short timer, transmit modes
  // ---------------------------------------------------------------

  // terminal count is the step from one to zero; zero itself wraps
  wire at_terminal = count_reg == irt_pkg::CNT_TERMINAL;

  always_comb begin
    state_next  = state_reg;
    count_next  = count_reg;
    out_next    = out_reg;
    second_next = second_reg;
    timeout_set = 1'b0;
    stop_hw     = 1'b0;
    case (state_reg)
      irt_pkg::IRT_IDLE: begin
        out_next = !init_level;
        if (enable_bit) begin
          state_next  = irt_pkg::IRT_RUN;
          out_next    = init_level;
          count_next  = hold_for(init_level, short_low_reg,
                                 short_high_reg);
          second_next = 1'b0;
        end
      end
      irt_pkg::IRT_RUN: begin
        if (!enable_bit) begin
          state_next = irt_pkg::IRT_IDLE;
          out_next   = !init_level;
        end else if (at_terminal) begin
          out_next = !out_reg;
          if (single_pass) begin
            count_next  = 8'h00;
            timeout_set = 1'b1;
            stop_hw     = 1'b1;
            state_next  = irt_pkg::IRT_IDLE;
          end else begin
            // reload picks the hold by the level just toggled to
            count_next  = hold_for(!out_reg, short_low_reg,
                                   short_high_reg);
            second_next = !second_reg;
            timeout_set = second_reg;
          end
        end else begin
          count_next = count_reg - 8'h01;
        end
      end
      default: begin
        state_next = irt_pkg::IRT_IDLE;
        out_next   = !init_level;
      end
    endcase
  end

  // timer state steps on every clock
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg  <= irt_pkg::IRT_IDLE;
      count_reg  <= 8'h00;
      out_reg    <= 1'b1;
      second_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      count_reg  <= count_next;
      out_reg    <= out_next;
      second_reg <= second_next;
    end
  end

  assign short_timer_output = out_reg;
  assign port3_pin4_output  = out_reg;
  assign port3_pin4_oe_n    = !short_ctrl_reg[irt_pkg::SC_OUT_EN];

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------

  // control register: software write, read clear, then hardware wins
  always_comb begin
    short_ctrl_next = short_ctrl_reg;
    if (wr_short_ctrl) begin
      short_ctrl_next = reg_wdata;
      // status is not writable; keep the held value
      short_ctrl_next[irt_pkg::SC_TIMEOUT] =
          short_ctrl_reg[irt_pkg::SC_TIMEOUT];
    end
    if (rd_short_ctrl) begin
      short_ctrl_next[irt_pkg::SC_TIMEOUT] = 1'b0;
    end
    if (stop_hw) begin
      short_ctrl_next[irt_pkg::SC_ENABLE] = 1'b0;
    end
    if (timeout_set) begin
      // set beats a same-cycle clearing read
      short_ctrl_next[irt_pkg::SC_TIMEOUT] = 1'b1;
    end
  end

  // control registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      short_ctrl_reg  <= irt_pkg::RST_CTRL;
      common_ctrl_reg <= irt_pkg::RST_CTRL;
      long_ctrl_reg   <= irt_pkg::RST_CTRL;
      extra_ctrl_reg  <= irt_pkg::RST_EXTRA;
    end else begin
      short_ctrl_reg <= short_ctrl_next;
      if (wr_common_ctrl) common_ctrl_reg <= reg_wdata;
      if (wr_long_ctrl)   long_ctrl_reg   <= reg_wdata;
      if (wr_extra_ctrl)  extra_ctrl_reg  <= reg_wdata;
    end
  end

  // holds take writes any time; counter sees them only at a load
  always_ff @(posedge mclk) begin
    if (reset) begin
      short_low_reg  <= irt_pkg::RST_HOLD;
      short_high_reg <= irt_pkg::RST_HOLD;
      long_low_reg   <= irt_pkg::RST_HOLD;
      long_high_reg  <= irt_pkg::RST_HOLD;
    end else begin
      if (wr_short_low)  short_low_reg  <= reg_wdata;
      if (wr_short_high) short_high_reg <= reg_wdata;
      if (wr_long_low)   long_low_reg   <= reg_wdata;
      if (wr_long_high)  long_high_reg  <= reg_wdata;
    end
  end

  // read mux; capture registers read zero since demodulation is absent
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_read) begin
      case (reg_addr)
        irt_pkg::ADDR_SHORT_CTRL:  rdata_next = short_ctrl_reg;
        irt_pkg::ADDR_COMMON_CTRL: rdata_next = common_ctrl_reg;
        irt_pkg::ADDR_LONG_CTRL:   rdata_next = long_ctrl_reg;
        irt_pkg::ADDR_EXTRA_CTRL:  rdata_next = extra_ctrl_reg;
        irt_pkg::ADDR_SHORT_LOW:   rdata_next = short_low_reg;
        irt_pkg::ADDR_SHORT_HIGH:  rdata_next = short_high_reg;
        irt_pkg::ADDR_LONG_LOW:    rdata_next = long_low_reg;
        irt_pkg::ADDR_LONG_HIGH:   rdata_next = long_high_reg;
        default:                   rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // level interrupt from status gated by its enable
  assign irq = short_ctrl_reg[irt_pkg::SC_TIMEOUT] &&
               short_ctrl_reg[irt_pkg::SC_TO_IRQ_EN];

endmodule : irt_timer

`default_nettype wire

// ---- irt_pkg.sv ----
// package: register map, field positions and filter widths of the ir timer
package irt_pkg;

  // register offsets on the 12-bit register port
  localparam logic [11:0] ADDR_SHORT_CTRL  = 12'hd00;
  localparam logic [11:0] ADDR_COMMON_CTRL = 12'hd01;
  localparam logic [11:0] ADDR_LONG_CTRL   = 12'hd02;
  localparam logic [11:0] ADDR_EXTRA_CTRL  = 12'hd03;
  localparam logic [11:0] ADDR_SHORT_LOW   = 12'hd04;
  localparam logic [11:0] ADDR_SHORT_HIGH  = 12'hd05;
  localparam logic [11:0] ADDR_LONG_LOW    = 12'hd06;
  localparam logic [11:0] ADDR_LONG_HIGH   = 12'hd07;
  localparam logic [11:0] ADDR_LCAP_LOW    = 12'hd08;
  localparam logic [11:0] ADDR_LCAP_HIGH   = 12'hd09;
  localparam logic [11:0] ADDR_SCAP_LOW    = 12'hd0a;
  localparam logic [11:0] ADDR_SCAP_HIGH   = 12'hd0b;

  // reset values
  localparam logic [7:0] RST_CTRL  = 8'h00;
  localparam logic [7:0] RST_EXTRA = 8'h00;
  localparam logic [7:0] RST_HOLD  = 8'h00;

  // short_timer_control fields
  localparam int SC_ENABLE     = 7;
  localparam int SC_SINGLE     = 6;
  localparam int SC_TIMEOUT    = 5;
  localparam int SC_TO_IRQ_EN  = 1;
  localparam int SC_OUT_EN     = 0;

  // timer_common_control fields
  localparam int CC_INPUT_SEL  = 6;
  localparam int CC_EDGE_HI    = 5;
  localparam int CC_EDGE_LO    = 4;
  localparam int CC_GLITCH_HI  = 3;
  localparam int CC_GLITCH_LO  = 2;
  localparam int CC_SHORT_INIT = 1;

  // edge select encodings
  localparam logic [1:0] EDGE_NONE    = 2'h0;
  localparam logic [1:0] EDGE_RISING  = 2'h1;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_ANY     = 2'h3;

  // glitch filter widths in clock cycles, per width code
  localparam logic [3:0] GLITCH_W0 = 4'h0;
  localparam logic [3:0] GLITCH_W1 = 4'h2;
  localparam logic [3:0] GLITCH_W2 = 4'h4;
  localparam logic [3:0] GLITCH_W3 = 4'h8;

  // counter values
  localparam logic [7:0] CNT_TERMINAL = 8'h01;

  // short timer state
  typedef enum logic [0:0] {
    IRT_IDLE = 1'b0,
    IRT_RUN  = 1'b1
  } irt_state_t;

endpackage : irt_pkg

// ---- irt_timer_props.sv ----
// checker: port-level properties of the ir timer
`timescale 1ns/1ps
`default_nettype none
module irt_timer_props #(
  parameter int GLITCH_CNT_W = 4
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // register port and interrupt
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic        irq,
  // input circuit and pin
  input wire logic        input_level,
  input wire logic        input_edge_pulse,
  input wire logic        short_timer_output,
  input wire logic        port3_pin4_output,
  input wire logic        port3_pin4_oe_n
);
  logic       ien_reg, oe_reg, init_reg;
  logic [1:0] esel_reg;
  logic [7:0] low_reg;
  logic [8:0] tmo_reg;
  // decode of the software accesses the shadows follow
  wire logic wr_sc = reg_write && reg_addr == 12'hd00;
  wire logic wr_cc = reg_write && reg_addr == 12'hd01;
  wire logic wr_lo = reg_write && reg_addr == 12'hd04;
  wire logic rd_dead = reg_read && (reg_addr > 12'hd07 || reg_addr < 12'hd00);
  wire logic sp_go = wr_sc && reg_wdata[7] && reg_wdata[6] && !init_reg;
  // shadows; tmo_reg counts to the single-pass terminal (init level 0 only)
  always_ff @(posedge mclk) begin
    if (reset) begin
      {ien_reg, oe_reg, init_reg, esel_reg} <= 5'h00;
      low_reg <= 8'h00;
      tmo_reg <= 9'h000;
    end else begin
      if (wr_sc) {ien_reg, oe_reg} <= reg_wdata[1:0];
      if (wr_cc) {esel_reg, init_reg} <= {reg_wdata[5:4], reg_wdata[1]};
      if (wr_lo) low_reg <= reg_wdata;
      if (sp_go) tmo_reg <= (low_reg == 8'h00) ? 9'h102 : low_reg + 9'h002;
      else if (tmo_reg != 9'h000) tmo_reg <= tmo_reg - 9'h001;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_pin; port3_pin4_output == short_timer_output; endproperty
  a_pin: assert property (p_pin) else $error("pin differs");
  property p_oe; port3_pin4_oe_n == !oe_reg; endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_idle;
    wr_sc && !reg_wdata[7] |-> ##2 short_timer_output == !init_reg;
  endproperty
  a_idle: assert property (p_idle) else $error("idle level");
  property p_start;
    wr_sc && reg_wdata[7] |-> ##2 short_timer_output == init_reg;
  endproperty
  a_start: assert property (p_start) else $error("start level");
  property p_term; tmo_reg == 9'h001 |-> $rose(short_timer_output); endproperty
  a_term: assert property (p_term) else $error("no toggle");
  property p_tirq; tmo_reg == 9'h001 && ien_reg |-> irq; endproperty
  a_tirq: assert property (p_tirq) else $error("no time-out irq");
  property p_quiet;
    tmo_reg >= 9'h002 && $past(tmo_reg) >= 9'h003 |->
      !short_timer_output && !irq;
  endproperty
  a_quiet: assert property (p_quiet) else $error("early end");
  property p_mask; irq |-> ien_reg; endproperty
  a_mask: assert property (p_mask) else $error("masked irq");
  property p_dead; rd_dead |=> reg_rdata == 8'h00; endproperty
  a_dead: assert property (p_dead) else $error("dead read");
  property p_hold;
    reg_read && reg_addr == 12'hd04 |=> reg_rdata == low_reg;
  endproperty
  a_hold: assert property (p_hold) else $error("hold read");
  property p_rdst; !reg_read |=> $stable(reg_rdata); endproperty
  a_rdst: assert property (p_rdst) else $error("read data moved");
  property p_edge;
    input_edge_pulse |-> input_level != $past(input_level) &&
      (esel_reg == 2'h3 || (esel_reg == 2'h1 && input_level) ||
       (esel_reg == 2'h2 && !input_level));
  endproperty
  a_edge: assert property (p_edge) else $error("edge pulse");
  property p_any;
    esel_reg == 2'h3 && input_level != $past(input_level) |-> input_edge_pulse;
  endproperty
  a_any: assert property (p_any) else $error("edge missed");
  c_term: cover property (tmo_reg == 9'h001);
  c_edge: cover property (input_edge_pulse);
  c_irq: cover property ($rose(irq));
endmodule : irt_timer_props
bind irt_timer irt_timer_props #(.GLITCH_CNT_W(GLITCH_CNT_W)) u_props (
  .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .irq(irq), .input_level(input_level), .input_edge_pulse(input_edge_pulse),
  .short_timer_output(short_timer_output),
  .port3_pin4_output(port3_pin4_output), .port3_pin4_oe_n(port3_pin4_oe_n));
`default_nettype wire

// ---- irt_src_model.sv ----
// partner: the four carrier sources in front of the input circuit
`timescale 1ns/1ps
`default_nettype none
module irt_src_model (
  // clock
  input  wire logic       mclk,
  // source the bench wants lit, and its level
  input  wire logic [1:0] src_sel,
  input  wire logic       lvl,
  // candidate sources
  output logic            port3_pin1_input,
  output logic            comparator_output,
  output logic            ir_amp_output,
  output logic            port2_pin0_input
);
  // others show the inverse, so a wrong pick reads back wrong
  always_ff @(posedge mclk) begin
    port3_pin1_input  <= (src_sel == 2'h0) ? lvl : !lvl;
    comparator_output <= (src_sel == 2'h1) ? lvl : !lvl;
    ir_amp_output     <= (src_sel == 2'h2) ? lvl : !lvl;
    port2_pin0_input  <= (src_sel == 2'h3) ? lvl : !lvl;
  end
endmodule : irt_src_model
`default_nettype wire

// ---- irt_timer_bench.sv ----
// testbench: registers, short timer transmit and input circuit
`timescale 1ns/1ps
`default_nettype none
module irt_timer_bench;
  logic        mclk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00, lo_v, hi_v, v, act;
  logic [1:0]  port3_mode = 2'h0, src_sel = 2'h0;
  logic        lvl = 1'b0, rd_d = 1'b0;
  wire logic [7:0] reg_rdata;
  wire logic   irq, input_level, input_edge_pulse, short_timer_output;
  wire logic   port3_pin4_output, port3_pin4_oe_n, p31, cmp, amp, p20;
  logic [7:0]  rq[$];
  logic [9:0]  oq[$], note;
  int          n_mismatch = 0, n_checks = 0, tally = 0, n_edge = 0, i, j;
  always #25 mclk = ~mclk;
  irt_timer #(.GLITCH_CNT_W(4)) u_dut (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .irq(irq), .port3_pin1_input(p31), .comparator_output(cmp),
    .ir_amp_output(amp), .port2_pin0_input(p20), .port3_mode(port3_mode),
    .input_level(input_level), .input_edge_pulse(input_edge_pulse),
    .short_timer_output(short_timer_output),
    .port3_pin4_output(port3_pin4_output), .port3_pin4_oe_n(port3_pin4_oe_n));
  irt_src_model u_src (.mclk(mclk), .src_sel(src_sel), .lvl(lvl),
    .port3_pin1_input(p31), .comparator_output(cmp), .ir_amp_output(amp),
    .port2_pin0_input(p20));
  task automatic final_report();
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic cmp8(input logic [7:0] act, input logic [7:0] exp);
    n_checks++;
    if (act !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask : cmp8
  // register cycles: one-cycle strobes, changed right after an edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge mclk);
    {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge mclk);
    reg_read <= 1'b0;
  endtask : rd
  // kind 0 pins, 1 cycle tally, 2 edge pulses
  task automatic look(input logic [1:0] k, input logic [7:0] e);
    oq.push_back({k, e});
  endtask : look
  task automatic wait_for(input logic use_irq, input logic want);
    for (int k = 0; k < 600; k++) begin
      if ((use_irq ? irq : short_timer_output) === want) return;
      @(negedge mclk);
      tally++;
    end
    n_mismatch++;
    final_report();
  endtask : wait_for
  task automatic pulse(input int w);
    n_edge = 0;
    lvl <= 1'b1;
    repeat (w) @(posedge mclk);
    lvl <= 1'b0;
    repeat (30) @(posedge mclk);
  endtask : pulse
  // read data is due the cycle after its strobe; pins are settled at negedge
  // looked at just after the negedge, so notes pushed there are seen
  // before wait_for bumps the tally again
  always @(posedge mclk) rd_d <= reg_read;
  always @(negedge mclk) begin
    #1;
    if (input_edge_pulse === 1'b1) n_edge++;
    if (rd_d) cmp8(reg_rdata, rq.pop_front());
    if (oq.size() > 0) begin
      note = oq.pop_front();
      act = note[9:8] == 2'h0 ? {4'h0, input_level, irq, port3_pin4_oe_n,
        short_timer_output} : note[9:8] == 2'h1 ? tally[7:0] : n_edge[7:0];
      cmp8(act, note[7:0]);
    end
  end
  initial begin
    void'($urandom(42));
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    for (i = 0; i < 13; i++) rd(12'hd00 + 12'(i), 8'h00);
    look(2'h0, 8'h03);
    lo_v = 8'($urandom_range(30, 4));
    hi_v = 8'($urandom_range(30, 4));
    v = 8'($urandom);
    wr(12'hd04, lo_v);
    wr(12'hd05, hi_v);
    wr(12'hd06, v);
    wr(12'hd0a, 8'hff);
    wr(12'hd00, 8'h20);
    rd(12'hd06, v);
    rd(12'hd0a, 8'h00);
    rd(12'hd00, 8'h00);
    // init level 1 first, so the timer scenarios start from level 0
    for (i = 0; i < 2; i++) begin
      wr(12'hd01, i[0] ? 8'h00 : 8'h02);
      repeat (2) @(posedge mclk);
      look(2'h0, {7'h01, i[0]});
    end
    // single pass from the low hold, then a zero count wrapping
    for (i = 0; i < 2; i++) begin
      if (i == 1) wr(12'hd04, 8'h00);
      wr(12'hd00, 8'hc3);
      tally = 0;
      wait_for(1'b1, 1'b1);
      look(2'h1, i == 0 ? lo_v + 8'h02 : 8'h02);
      look(2'h0, 8'h05);
      rd(12'hd00, 8'h63);
      @(posedge mclk);
      look(2'h0, 8'h01);
    end
    // repeating mode: quiet toggle, then toggle with time-out
    wr(12'hd04, lo_v);
    wr(12'hd00, 8'h83);
    tally = 0;
    wait_for(1'b0, 1'b0);
    wait_for(1'b0, 1'b1);
    look(2'h1, lo_v + 8'h02);
    look(2'h0, 8'h01);
    wait_for(1'b1, 1'b1);
    look(2'h1, lo_v + hi_v + 8'h02);
    look(2'h0, 8'h04);
    wr(12'hd00, 8'h03);
    rd(12'hd00, 8'h23);
    @(posedge mclk);
    look(2'h0, 8'h01);
    // each source choice, level high then low
    for (i = 0; i < 5; i++) begin
      port3_mode <= i == 4 ? 2'h0 : 2'(i);
      src_sel <= i == 4 ? 2'h3 : i == 3 ? 2'h2 : 2'(i);
      wr(12'hd01, i == 4 ? 8'h70 : 8'h30);
      for (j = 0; j < 2; j++) begin
        lvl <= !j[0];
        repeat (20) @(posedge mclk);
        look(2'h0, j == 0 ? 8'h09 : 8'h01);
      end
    end
    port3_mode <= 2'h0;
    src_sel <= 2'h0;
    for (i = 0; i < 4; i++) begin
      wr(12'hd01, {2'h0, 2'(i), 4'h0});
      pulse(12);
      look(2'h2, i == 3 ? 8'h02 : i == 0 ? 8'h00 : 8'h01);
    end
    // filter widths 2, 4, 8: half width swallowed, longer passes
    for (i = 1; i < 4; i++) begin
      wr(12'hd01, {4'h3, 2'(i), 2'h0});
      pulse(1 << (i - 1));
      look(2'h2, 8'h00);
      pulse((2 << i) + 8);
      look(2'h2, 8'h02);
    end
    repeat (2) @(posedge mclk);
    final_report();
  end
endmodule : irt_timer_bench
`default_nettype wire
